// ---- dv/hall_model.sv ----
/* Hall sensor model of the motor side.
   Assumes clk_in is the core clock; one sector step per period_in+1 cycles. */
`timescale 1ns/1ns
module hall_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        run_in,
  input  wire logic        rev_in,
  input  wire logic [15:0] period_in,
  output logic      [2:0]  hall_out
);
  logic [2:0]  sect_q;
  logic [15:0] cnt_q;
  // Sector to forward sensor pattern
  always_comb begin
    case (sect_q)
      3'h0: hall_out = 3'h5;
      3'h1: hall_out = 3'h4;
      3'h2: hall_out = 3'h6;
      3'h3: hall_out = 3'h2;
      3'h4: hall_out = 3'h3;
      default: hall_out = 3'h1;
    endcase
  end
  // Step one sector each period, backward when reversed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sect_q <= 3'h0;
      cnt_q  <= 16'h0000;
    end else if (run_in) begin
      cnt_q <= (cnt_q >= period_in) ? 16'h0000 : cnt_q + 16'h0001;
      if (cnt_q >= period_in) begin
        if (rev_in) sect_q <= (sect_q == 3'h0) ? 3'h5 : sect_q - 3'h1;
        else sect_q <= (sect_q == 3'h5) ? 3'h0 : sect_q + 3'h1;
      end
    end
  end
endmodule

// ---- dv/tb_top.sv ----
/* Self-checking bench of the motor sequencer.
   Assumes hall_model as the motor side and shortened counts. */
`timescale 1ns/1ns
module tb_top;
  import motor_seq_pkg::*;
  logic        clk = 0, rst_n = 0, good = 0, lsel = 0, dtest = 0, run = 0, rev = 0, tsel = 0;
  logic [6:0]  code = 7'h00;
  logic [15:0] per = 16'h012C;
  logic [2:0]  hall, hs, ls, hs_or, ls_or;
  logic        tach, lockf, sine, test, hot, adv, lpe, rdir;
  int          n_fail = 0, n_compared = 0, hs_n, tg_n, n30;
  always #25 clk = ~clk;
  motor_startup_speed_sequencer #(.KICK_LEN(50), .LOCK_LEN(400), .FAST_LEN(200)) DUT (
    .clk_in(clk), .rst_n_in(rst_n), .supply_good_in(good), .speed_code_in(code),
    .position_sense_in(hall), .lock_protect_select_in(lsel), .direction_select_in(1'b0),
    .dir_test_level_in(dtest), .tach_pulse_select_in(tsel), .high_side_out(hs),
    .low_side_out(ls), .tach_output_out(tach), .lock_fault_out(lockf), .sine_mode_out(sine),
    .test_mode_out(test), .thermal_shutdown_en_out(hot), .advance_zero_out(adv),
    .lock_protect_en_out(lpe), .reverse_dir_out(rdir));
  hall_model motor (.clk_in(clk), .rst_n_in(rst_n), .run_in(run), .rev_in(rev),
    .period_in(per), .hall_out(hall));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Gather gate and tach activity over n cycles
  task automatic scan(input int n);
    logic t;
    hs_n = 0; tg_n = 0; hs_or = 3'h0; ls_or = 3'h0;
    repeat (n) begin
      t = tach;
      tick(1);
      hs_n += int'(hs != 3'h0);
      tg_n += int'(tach !== t);
      hs_or |= hs;
      ls_or |= ls;
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    tick(2);
    chk({hs, ls}, 8'h00);
    chk(hot, 8'h01);
    rst_n = 1'b1;
    tick(3);
    chk({lpe, hs, ls}, 8'h00);
    good = 1'b1; // Lock enabled, main supply assumed up in time
    tick(2);
    lsel = 1'b1;
    tick(2);
    chk(lpe, 8'h01);
    code = 7'h05; // Command raised after supplies
    tick(4);
    chk({hs, ls}, 8'h00);
    code = 7'h14;
    scan(130);
    chk(ls_or, 8'h07);
    chk(hs_or, 8'h00);
    run = 1'b1; // Slow steps keep the lock timer from expiring
    code = 7'h1E;
    tick(4);
    chk(ls, 8'h01);
    code = 7'h7F;
    tick(130);
    scan(127);
    chk(hs_n, 8'h7F);
    chk(hs_or, 8'h02);
    code = 7'h1E;
    tick(130);
    scan(127);
    n30 = hs_n;
    code = 7'h3C;
    tick(130);
    scan(127);
    chk(hs_n > n30, 8'h01);
    chk(sine, 8'h00);
    run = 1'b0;
    tick(410);
    chk({lockf, hs, ls}, 8'h40);
    code = 7'h00;
    tick(4);
    chk(lockf, 8'h00);
    code = 7'h50;
    scan(45);
    chk(hs_or, 8'h00);
    scan(20);
    chk(hs_or, 8'h04);
    per = 16'h0014;
    run = 1'b1;
    tick(300);
    chk(sine, 8'h01);
    scan(126);
    chk(tg_n, 8'h06);
    rev = 1'b1;
    for (int i = 0; i < 30 && rdir !== 1'b1; i++) tick(1);
    chk(rdir, 8'h01);
    chk(sine, 8'h00);
    rst_n = 1'b0;
    run = 1'b0;
    rev = 1'b0;
    code = 7'h6E;
    dtest = 1'b1;
    tsel = 1'b1;
    tick(2);
    rst_n = 1'b1;
    tick(4);
    chk({test, hot, adv}, 8'h05);
    // Test mode: high side full on despite a low duty
    code = 7'h1E;
    tick(60);
    scan(127);
    chk(hs_n, 8'h7F);
    // One tach pulse per turn: two toggles over six steps
    run = 1'b1;
    tick(30);
    scan(126);
    chk(tg_n, 8'h02);
    // Coasting fast in the charge band: no charging
    code = 7'h14;
    tick(2);
    scan(130);
    chk(ls_or, 8'h00);
    close_out();
  end
  // Watchdog well beyond the expected run
  initial begin
    #600000;
    n_fail++;
    close_out();
  end
endmodule

// ---- rtl/hall_tracker.sv ----
/*
 Position sensor tracker: sector, edge timing, coasting speed, reverse
 detection, sub-sector angle and tach output. Assumes synchronous inputs.
*/
`timescale 1ns/1ns
module hall_tracker
  import motor_seq_pkg::*;
#(
  parameter int FAST_LIM = FAST_CYC,
  parameter int CW       = 23
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] hall_in,
  input  wire logic       dir_in,
  input  wire logic       tach_sel_in,
  output logic      [2:0] sector_out,
  output logic      [2:0] sub_out,
  output logic            edge_out,
  output logic            reverse_out,
  output logic            fast_out,
  output logic            tach_out
);

  // ************************************************************
  // Edge timing state
  // ************************************************************
  logic [2:0]    h_q, h_d, sub_q, sub_d;
  logic [CW-1:0] cnt_q, cnt_d, per_q, per_d, tk_q, tk_d;
  logic          fast_q, fast_d, tach_q, tach_d, seen_q, seen_d;
  logic [2:0]    sect_now, sect_old;

  assign sect_now = hall_sector(hall_in, dir_in);
  assign sect_old = hall_sector(h_q, dir_in);
  assign edge_out = seen_q && (hall_in != h_q);  // No false edge from the reset pattern
  // Previous sector reached again means turning backwards
  assign reverse_out = edge_out && sect_now != SECT_NONE && sect_old != SECT_NONE
                       && next_sector(sect_now) == sect_old;

  // Next values of the timing group
  always_comb begin
    h_d    = hall_in;
    seen_d = 1'b1;
    cnt_d  = (cnt_q == {CW{1'b1}}) ? cnt_q : CW'(cnt_q + 1'b1);
    per_d  = per_q;
    tk_d   = CW'(tk_q + 1'b1);
    sub_d  = sub_q;
    fast_d = fast_q;
    tach_d = tach_q;
    if (tk_q >= (per_q >> 3) && sub_q != 3'h7) begin
      tk_d  = '0;
      sub_d = 3'(sub_q + 3'h1);
    end
    if (cnt_q >= CW'(FAST_LIM)) begin
      fast_d = 1'b0;
    end
    if (edge_out) begin
      cnt_d  = '0;
      per_d  = cnt_q;
      tk_d   = '0;
      sub_d  = '0;
      fast_d = (cnt_q < CW'(FAST_LIM)) && !reverse_out;
      // Every phase edge, or U edges only for one pulse a turn
      if (!tach_sel_in || (hall_in[2] != h_q[2])) begin  // [RL19]
        tach_d = !tach_q;
      end
    end
  end

  // Register the timing group
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      h_q    <= '0;
      seen_q <= 1'b0;
      cnt_q  <= '1;
      per_q  <= '1;
      tk_q   <= '0;
      sub_q  <= '0;
      fast_q <= 1'b0;
      tach_q <= 1'b0;
    end else begin
      h_q    <= h_d;
      seen_q <= seen_d;
      cnt_q  <= cnt_d;
      per_q  <= per_d;
      tk_q   <= tk_d;
      sub_q  <= sub_d;
      fast_q <= fast_d;
      tach_q <= tach_d;
    end
  end

  assign sector_out = sect_now;
  assign sub_out    = sub_q;
  assign fast_out   = fast_q;
  assign tach_out   = tach_q;

  a_tach_every_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL19]
    (edge_out && !tach_sel_in) |=> (tach_q != $past(tach_q)))
    else $error("tach did not toggle on a sensor edge");

endmodule

// ---- rtl/motor_seq_pkg.sv ----
/*
 Shared constants, state type and decode functions of the motor startup
 and speed sequencer. Assumes a 20 MHz core clock and a 7-bit speed code.
*/
package motor_seq_pkg;

  // ************************************************************
  // Clock and converter scaling
  // ************************************************************
  localparam int CLK_HZ    = 20_000_000;
  localparam int CODE_W    = 7;
  localparam int ADC_FS_MV = 10000;  // Converter full scale over 128 codes

  // Speed command band edges in millivolts
  localparam int CMD_OFF_MV  = 1000;
  localparam int CMD_CTRL_MV = 2100;
  localparam int CMD_FULL_MV = 5400;
  localparam int CMD_TEST_MV = 8100;

  // Voltage to code, rounded up
  function automatic logic [CODE_W-1:0] mv_to_code(input int mv);
    return CODE_W'((mv * (1 << CODE_W) + ADC_FS_MV - 1) / ADC_FS_MV);
  endfunction

  localparam logic [CODE_W-1:0] CODE_OFF  = mv_to_code(CMD_OFF_MV);
  localparam logic [CODE_W-1:0] CODE_CTRL = mv_to_code(CMD_CTRL_MV);
  localparam logic [CODE_W-1:0] CODE_FULL = mv_to_code(CMD_FULL_MV);
  localparam logic [CODE_W-1:0] CODE_TEST = mv_to_code(CMD_TEST_MV);
  localparam logic [CODE_W-1:0] DUTY_MAX  = 7'h7F;
  localparam int                DUTY_GAIN = 3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int KICK_US     = 9000;
  localparam int KICK_CYC    = KICK_US * (CLK_HZ / 1_000_000);
  localparam int HALL_MIN_HZ = 1;
  localparam int FAST_CYC    = CLK_HZ / (6 * HALL_MIN_HZ);
  localparam int LOCK_MS     = 1000;
  localparam int LOCK_CYC    = LOCK_MS * (CLK_HZ / 1000);
  localparam int CHARGE_CYC  = 16;

  localparam logic [2:0] SECT_NONE = 3'h7;

  typedef enum logic [2:0] {
    ST_OFF, ST_SAMPLE, ST_WAIT, ST_CHARGE, ST_KICK, ST_RUN, ST_LOCK
  } seq_state_t;

  // Hall pattern to 60 degree sector, reverse uses inverted pattern
  function automatic logic [2:0] hall_sector(input logic [2:0] h, input logic rev);
    case (h ^ {3{rev}})
      3'h5:    return 3'h0;
      3'h4:    return 3'h1;
      3'h6:    return 3'h2;
      3'h2:    return 3'h3;
      3'h3:    return 3'h4;
      3'h1:    return 3'h5;
      default: return SECT_NONE;
    endcase
  endfunction

  // Sector that follows in the selected direction
  function automatic logic [2:0] next_sector(input logic [2:0] s);
    return (s == 3'h5) ? 3'h0 : 3'(s + 3'h1);
  endfunction

endpackage

// ---- rtl/motor_startup_speed_sequencer.sv ----
/*
 Startup and speed sequencer of a three-phase motor driver: strap capture,
 speed bands, bootstrap charging, trapezoidal and sine drive, lock and
 test mode. Assumes supply_good_in is the logic supply turn-on indication
 and speed_code_in is the converted speed command, both synchronous.
*/
`timescale 1ns/1ns

// Function
// RL1 - Start only after logic supply is good
// RL2 - Latch three straps once at startup
// RL3 - Wait for controllable speed command before driving
// RL4 - Below lowest band all drives off
// RL5 - Charging band pulses low sides each cycle
// RL6 - No charging while motor coasts fast
// RL7 - Sudden jump: charge fixed time first
// RL8 - Control band duty follows speed command
// RL9 - Duty from 7-bit code, monotonic
// RL10 - At upper limit full duty
// RL11 - Slow position signal: trapezoidal drive
// RL12 - Fast position signal: sine drive
// RL13 - Reverse rotation drops to trapezoidal immediately
// RL14 - Controller raises command last, lowers first
// RL15 - Controller applies main supply before lock time
// RL16 - No position change too long: lock
// RL17 - Test: full high side, no thermal, zero advance; in sine drive the high side still follows the PWM
// RL18 - Test entry: high command, mid direction level
// RL19 - Tach three pulses or one per turn
// RL20 - Band thresholds as code comparisons
module motor_startup_speed_sequencer
  import motor_seq_pkg::*;
#(
  parameter int KICK_LEN = KICK_CYC,
  parameter int LOCK_LEN = LOCK_CYC,
  parameter int FAST_LEN = FAST_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              supply_good_in,
  input  wire logic [CODE_W-1:0] speed_code_in,
  input  wire logic [2:0]        position_sense_in,
  input  wire logic              lock_protect_select_in,
  input  wire logic              direction_select_in,
  input  wire logic              dir_test_level_in,
  input  wire logic              tach_pulse_select_in,
  output logic      [2:0]        high_side_out,
  output logic      [2:0]        low_side_out,
  output logic                   tach_output_out,
  output logic                   lock_fault_out,
  output logic                   sine_mode_out,
  output logic                   test_mode_out,
  output logic                   thermal_shutdown_en_out,
  output logic                   advance_zero_out,
  output logic                   lock_protect_en_out,
  output logic                   reverse_dir_out
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Duty from speed code, rises with the code
  function automatic logic [CODE_W-1:0] duty_of(input logic [CODE_W-1:0] c);
    logic [CODE_W+2:0] t;
    t = '0;
    if (c < CODE_CTRL) begin
      return '0;
    end else if (c >= CODE_FULL) begin
      return DUTY_MAX;  // [RL10]
    end
    t = (CODE_W+3)'(c - CODE_CTRL) * (CODE_W+3)'(DUTY_GAIN);  // [RL9]
    return (t > (CODE_W+3)'(DUTY_MAX)) ? DUTY_MAX : t[CODE_W-1:0];
  endfunction

  // Sine level at 7.5 degree steps, centred on mid duty
  function automatic logic [6:0] sine_of(input logic [5:0] a);
    logic [4:0] k;
    logic [5:0] v;
    k = (a >= 6'd24) ? 5'(a - 6'd24) : a[4:0];
    if (k > 5'd12) begin
      k = 5'(5'd24 - k);
    end
    case (k)
      5'd0:    v = 6'h00;
      5'd1:    v = 6'h08;
      5'd2:    v = 6'h10;
      5'd3:    v = 6'h18;
      5'd4:    v = 6'h20;
      5'd5:    v = 6'h26;
      5'd6:    v = 6'h2D;
      5'd7:    v = 6'h32;
      5'd8:    v = 6'h37;
      5'd9:    v = 6'h3A;
      5'd10:   v = 6'h3D;
      5'd11:   v = 6'h3E;
      default: v = 6'h3F;
    endcase
    return (a >= 6'd24) ? 7'(7'h40 - v) : 7'(7'h40 + v);
  endfunction

  // Angle shifted by s steps (16 or 32, a third or two thirds of a turn), modulo 48 steps
  function automatic logic [5:0] shift_angle(input logic [5:0] a, input logic [5:0] s);
    logic [6:0] t;
    t = 7'(a) + 7'(s);
    return (t >= 7'd48) ? 6'(t - 7'd48) : t[5:0];
  endfunction

  // Scale the speed duty by a sine level
  function automatic logic [6:0] scale(input logic [6:0] d, input logic [6:0] s);
    logic [13:0] p;
    p = 14'(d) * 14'(s);
    return p[13:7];
  endfunction

  // Trapezoidal masks {high, low} per sector, bit 0 is phase U
  function automatic logic [5:0] trap_masks(input logic [2:0] s);
    case (s)
      3'h0:    return 6'h11;
      3'h1:    return 6'h21;
      3'h2:    return 6'h22;
      3'h3:    return 6'h0A;
      3'h4:    return 6'h0C;
      3'h5:    return 6'h14;
      default: return 6'h00;
    endcase
  endfunction

  // ************************************************************
  // Sub-blocks
  // ************************************************************
  logic [2:0]        sector, sub, pwm;
  logic [CODE_W-1:0] pwm_cnt;
  logic              hall_edge, reverse, fast;
  logic [CODE_W-1:0] duty_a, duty_b, duty_c;
  logic              dir_q, dir_d, tsel_q, tsel_d;

  hall_tracker #(
    .FAST_LIM (FAST_LEN)
  ) u_hall (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .hall_in     (position_sense_in),
    .dir_in      (dir_q),
    .tach_sel_in (tsel_q),
    .sector_out  (sector),
    .sub_out     (sub),
    .edge_out    (hall_edge),
    .reverse_out (reverse),
    .fast_out    (fast),
    .tach_out    (tach_output_out)
  );

  speed_pwm #(
    .W (CODE_W)
  ) u_pwm (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .duty_a_in (duty_a),
    .duty_b_in (duty_b),
    .duty_c_in (duty_c),
    .pwm_out   (pwm),
    .count_out (pwm_cnt)
  );

  // ************************************************************
  // Sequencer state
  // ************************************************************
  localparam int KW = $clog2(KICK_LEN + 1);
  localparam int LW = $clog2(LOCK_LEN + 1);

  seq_state_t        state_q, state_d;
  logic [KW-1:0]     kick_q, kick_d;
  logic [LW-1:0]     lcnt_q, lcnt_d;
  logic              lock_en_q, lock_en_d;
  logic              test_q, test_d, hot_en_q, hot_en_d;
  logic              sine_q, sine_d, revf_q, revf_d;
  logic [CODE_W-1:0] duty_q, duty_d;
  logic              in_charge_band;

  assign in_charge_band = speed_code_in >= CODE_OFF && speed_code_in < CODE_CTRL;  // [RL20]

  // Next state, strap capture and timers
  always_comb begin
    state_d   = state_q;
    kick_d    = kick_q;
    lcnt_d    = '0;
    lock_en_d = lock_en_q;
    dir_d     = dir_q;
    tsel_d    = tsel_q;
    test_d    = test_q;
    hot_en_d  = hot_en_q;
    case (state_q)
      ST_OFF: begin
        if (supply_good_in) begin  // [RL1]
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        lock_en_d = !lock_protect_select_in;  // [RL2]
        dir_d     = direction_select_in;
        tsel_d    = tach_pulse_select_in;
        test_d    = speed_code_in >= CODE_TEST && dir_test_level_in;  // [RL18]
        hot_en_d  = !(speed_code_in >= CODE_TEST && dir_test_level_in);  // [RL17]
        state_d   = ST_WAIT;
      end
      ST_WAIT: begin
        if (speed_code_in >= CODE_CTRL) begin  // [RL3] [RL7]
          state_d = ST_KICK;
          kick_d  = '0;
        end else if (in_charge_band && !fast) begin  // [RL5] [RL6]
          state_d = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (speed_code_in < CODE_OFF || fast) begin  // [RL4] [RL6]
          state_d = ST_WAIT;
        end else if (speed_code_in >= CODE_CTRL) begin
          state_d = ST_RUN;
        end
      end
      ST_KICK: begin
        if (kick_q == KW'(KICK_LEN - 1)) begin  // [RL7]
          state_d = ST_RUN;
        end else begin
          kick_d = KW'(kick_q + 1'b1);
        end
      end
      ST_RUN: begin
        lcnt_d = hall_edge ? '0 : LW'(lcnt_q + 1'b1);
        if (speed_code_in < CODE_CTRL) begin
          state_d = ST_WAIT;
        end else if (lock_en_q && lcnt_q == LW'(LOCK_LEN - 1)) begin  // [RL16]
          state_d = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (speed_code_in < CODE_OFF) begin
          state_d = ST_WAIT;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (!supply_good_in) begin  // [RL1]
      state_d = ST_OFF;
    end
  end

  // Register sequencer state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q   <= ST_OFF;
      kick_q    <= '0;
      lcnt_q    <= '0;
      lock_en_q <= 1'b0;
      dir_q     <= 1'b0;
      tsel_q    <= 1'b0;
      test_q    <= 1'b0;
      hot_en_q  <= 1'b1;
    end else begin
      state_q   <= state_d;
      kick_q    <= kick_d;
      lcnt_q    <= lcnt_d;
      lock_en_q <= lock_en_d;
      dir_q     <= dir_d;
      tsel_q    <= tsel_d;
      test_q    <= test_d;
      hot_en_q  <= hot_en_d;
    end
  end

  // ************************************************************
  // Drive mode and duty
  // ************************************************************
  logic [5:0] ang_u;

  assign ang_u  = 6'(sector * 4'd8) + 6'(sub);
  assign duty_a = sine_q ? scale(duty_q, sine_of(ang_u)) : duty_q;
  assign duty_b = sine_q ? scale(duty_q, sine_of(shift_angle(ang_u, 6'd32))) : duty_q;
  assign duty_c = sine_q ? scale(duty_q, sine_of(shift_angle(ang_u, 6'd16))) : duty_q;

  // Sine only after a fast edge, dropped at once on reverse
  always_comb begin
    duty_d = duty_of(speed_code_in);  // [RL8] [RL9]
    revf_d = reverse;
    sine_d = state_q == ST_RUN && fast && !reverse && sector != SECT_NONE
             && (sine_q || hall_edge);  // [RL11] [RL12] [RL13]
  end

  // Register mode and duty
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      duty_q <= '0;
      sine_q <= 1'b0;
      revf_q <= 1'b0;
    end else begin
      duty_q <= duty_d;
      sine_q <= sine_d;
      revf_q <= revf_d;
    end
  end

  // ************************************************************
  // Gate drive outputs
  // ************************************************************
  logic [2:0] hs_q, hs_d, ls_q, ls_d;
  logic       lockf_q, lockf_d;
  logic [5:0] tm;

  assign tm = trap_masks(sector);

  // Gate pattern per state and drive mode
  always_comb begin
    hs_d    = '0;
    ls_d    = '0;
    lockf_d = state_q == ST_LOCK;  // [RL16]
    case (state_q)
      ST_CHARGE, ST_KICK: begin
        ls_d = {3{pwm_cnt < CODE_W'(CHARGE_CYC)}};  // [RL5] [RL7]
      end
      ST_RUN: begin
        if (sine_q) begin
          hs_d = pwm;  // [RL12]
          ls_d = ~pwm;
        end else begin
          hs_d = tm[5:3] & (test_q ? 3'h7 : pwm);  // [RL11] [RL17]
          ls_d = tm[2:0];
        end
      end
      default: begin
        hs_d = '0;  // [RL4]
        ls_d = '0;
      end
    endcase
  end

  // Register gate outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_q    <= '0;
      ls_q    <= '0;
      lockf_q <= 1'b0;
    end else begin
      hs_q    <= hs_d;
      ls_q    <= ls_d;
      lockf_q <= lockf_d;
    end
  end

  assign high_side_out           = hs_q;
  assign low_side_out            = ls_q;
  assign lock_fault_out          = lockf_q;
  assign sine_mode_out           = sine_q;
  assign test_mode_out           = test_q;
  assign thermal_shutdown_en_out = hot_en_q;
  assign advance_zero_out        = test_q;
  assign lock_protect_en_out     = lock_en_q;
  assign reverse_dir_out         = revf_q;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence kick_then_run;
    state_q == ST_KICK ##1 state_q == ST_RUN;
  endsequence

  a_off_without_supply: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL1]
    !supply_good_in |-> ##2 (hs_q == 3'h0 && ls_q == 3'h0))
    else $error("gates driven without supply good");

  a_straps_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL2]
    state_q != ST_SAMPLE |=> ($stable(dir_q) && $stable(lock_en_q) && $stable(tsel_q)))
    else $error("strap changed outside sampling");

  a_wait_drives_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL4]
    state_q == ST_WAIT |=> (hs_q == 3'h0 && ls_q == 3'h0))
    else $error("gates driven while waiting");

  a_charge_low_side: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL5]
    (state_q == ST_CHARGE && pwm_cnt == 7'h00) |=> (ls_q == 3'h7 && hs_q == 3'h0))
    else $error("bootstrap charge pulse missing");

  a_coast_no_charge: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL6]
    (state_q == ST_WAIT && fast && in_charge_band && supply_good_in) |=> state_q == ST_WAIT)
    else $error("charging while coasting");

  a_kick_full_length: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL7]
    kick_then_run |-> $past(kick_q) == KW'(KICK_LEN - 1))
    else $error("charge interval wrong length");

  a_duty_rises: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL9]
    ($past(speed_code_in) < speed_code_in) |=> duty_q >= $past(duty_q))
    else $error("duty fell for a higher command");

  a_full_duty: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL10]
    speed_code_in >= CODE_FULL |=> duty_q == DUTY_MAX)
    else $error("full duty not reached");

  a_reverse_trap: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL13]
    reverse |=> !sine_q)
    else $error("sine kept after reverse rotation");

  a_lock_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL16]
    (state_q == ST_RUN && lock_en_q && lcnt_q == LW'(LOCK_LEN - 1) && supply_good_in
     && speed_code_in >= CODE_CTRL) |=> state_q == ST_LOCK ##1 lock_fault_out)
    else $error("lock not entered after stall");

  a_test_high_full: assert property (@(posedge clk_in) disable iff (!rst_n_in)  // [RL17]
    (test_q && state_q == ST_RUN && !sine_q && sector != SECT_NONE) |=> hs_q != 3'h0)
    else $error("test mode high side not full on");

endmodule

// ---- rtl/speed_pwm.sv ----
/*
 Three-channel PWM carrier. Assumes duties are held steady by the caller;
 a duty of all ones drives the channel on for the whole period.
*/
`timescale 1ns/1ns
module speed_pwm #(
  parameter int W = 7
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] duty_a_in,
  input  wire logic [W-1:0] duty_b_in,
  input  wire logic [W-1:0] duty_c_in,
  output logic      [2:0]   pwm_out,
  output logic      [W-1:0] count_out
);

  // ************************************************************
  // Carrier counter, 0 to 2^W-2
  // ************************************************************
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Next count, wraps one short of all ones
  always_comb begin
    cnt_d = (cnt_q == {{(W-1){1'b1}}, 1'b0}) ? '0 : W'(cnt_q + 1'b1);
  end

  // Register the count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Compare each channel against the carrier
  assign pwm_out   = {cnt_q < duty_c_in, cnt_q < duty_b_in, cnt_q < duty_a_in};
  assign count_out = cnt_q;

endmodule
